//--- pas_pkg.sv
// Constants for the auto-negotiation and unit status register bank
package pas_pkg;
    localparam logic [4:0] PAS_OFS_BASIC_CTRL = 5'h00;
    localparam logic [4:0] PAS_OFS_ADVERTISE = 5'h04;
    localparam logic [4:0] PAS_OFS_PARTNER = 5'h05;
    localparam logic [4:0] PAS_OFS_EXPANSION = 5'h06;
    localparam logic [4:0] PAS_OFS_RSVD_LO = 5'h08;
    localparam logic [4:0] PAS_OFS_RSVD_HI = 5'h0F;
    localparam logic [4:0] PAS_OFS_UNIT_STATUS = 5'h10;
    // Basic control field positions
    localparam int PAS_BC_SPEED_BIT = 13;
    localparam int PAS_BC_AN_EN_BIT = 12;
    localparam int PAS_BC_RESTART_BIT = 9;
    localparam int PAS_BC_DUPLEX_BIT = 8;
    localparam logic PAS_BC_SPEED_RST = 1'h1;
    localparam logic PAS_BC_AN_EN_RST = 1'h1;
    localparam logic PAS_BC_DUPLEX_RST = 1'h0;
    // Advertisement fields
    localparam int PAS_ADV_NEXT_PAGE_BIT = 15;
    localparam int PAS_ADV_ACK_BIT = 14;
    localparam int PAS_ADV_RFAULT_BIT = 13;
    localparam int PAS_ADV_TECH_HI = 12;
    localparam int PAS_ADV_TECH_LO = 5;
    localparam logic PAS_ADV_RFAULT_RST = 1'h0;
    localparam logic [7:0] PAS_ADV_TECH_RST = 8'h2F;
    localparam logic [4:0] PAS_ADV_SELECTOR = 5'h01;
    // Technology field bit positions (within the 8-bit field)
    localparam int PAS_TECH_10HD = 0;
    localparam int PAS_TECH_10FD = 1;
    localparam int PAS_TECH_100HD = 2;
    localparam int PAS_TECH_100FD = 3;
    localparam int PAS_TECH_T4 = 4;
    // Expansion fields
    localparam int PAS_EXP_PD_FAULT_BIT = 4;
    localparam int PAS_EXP_LP_NP_BIT = 3;
    localparam int PAS_EXP_NP_ABLE_BIT = 2;
    localparam int PAS_EXP_PAGE_RX_BIT = 1;
    localparam int PAS_EXP_LP_AN_BIT = 0;
    localparam logic PAS_EXP_NP_ABLE = 1'h0;
    // Unit status and control fields
    localparam int PAS_US_RSVD_HI = 15;
    localparam int PAS_US_RSVD_LO = 14;
    localparam int PAS_US_DISC_BIT = 13;
    localparam int PAS_US_TXFC_BIT = 12;
    localparam int PAS_US_SYNC_BIT = 11;
    localparam int PAS_US_PD100_BIT = 10;
    localparam int PAS_US_PD10_BIT = 9;
    localparam int PAS_US_POL_BIT = 8;
    localparam int PAS_US_SPEED_BIT = 1;
    localparam int PAS_US_DUPLEX_BIT = 0;
    localparam logic [1:0] PAS_US_RSVD_RST = 2'h0;
    localparam logic PAS_US_DISC_RST = 1'h0;
    localparam logic PAS_US_TXFC_RST = 1'h0;
    // Synchronised status: {sync, pd100, pd10, polarity}
    localparam logic [3:0] PAS_STAT_RST = 4'h6;
endpackage : pas_pkg

//--- pas_sync.sv
// Two-flop synchroniser with a constant reset value
`timescale 1ns/1ns
module pas_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RST_VAL = '0
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_n_in,
    // Data
    input wire logic [WIDTH-1:0] d_in,
    output logic [WIDTH-1:0] q_out
);
    logic [WIDTH-1:0] meta_q;

    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            meta_q <= RST_VAL;
            q_out <= RST_VAL;
        end
        else
        begin
            meta_q <= d_in;
            q_out <= meta_q;
        end
    end
endmodule : pas_sync

//--- pas_resolve.sv
// Highest common denominator speed and duplex resolution
`timescale 1ns/1ns
module pas_resolve (
    // Abilities
    input wire logic [7:0] local_tech_in,
    input wire logic [7:0] partner_tech_in,
    // Result
    output logic speed_100_out,
    output logic full_duplex_out
);
    logic [7:0] common;

    always_comb
    begin
        common = local_tech_in & partner_tech_in;
        speed_100_out = 1'b0;
        full_duplex_out = 1'b0;
        // Priority: 100 full, 100 half or T4, 10 full, 10 half
        if (common[pas_pkg::PAS_TECH_100FD])
        begin
            speed_100_out = 1'b1;
            full_duplex_out = 1'b1;
        end
        else if (common[pas_pkg::PAS_TECH_100HD]
                 || common[pas_pkg::PAS_TECH_T4])
        begin
            speed_100_out = 1'b1;
        end
        else if (common[pas_pkg::PAS_TECH_10FD])
        begin
            full_duplex_out = 1'b1;
        end
    end
endmodule : pas_resolve

//--- pas_regs.sv
// Auto-negotiation and unit status/control register bank
// Functional notes
// - Advertisement bit 15 always reads zero; writes to it are ignored.
// - Advertisement bit 13 writable, resets zero, sends remote fault.
// - Advertisement bits 12:5 writable, reset 00101111, sent to partner.
// - Advertisement bits 4:0 read-only constant 00001.
// - Partner register is read-only and shows the received base page.
// - Partner bit 14 set once the partner page has been received.
// - Expansion bit 4 latches parallel detect fault, clears on read.
// - Expansion bit 1 latches new page arrival, clears on read.
// - Expansion bit 3 partner next page able, bit 0 partner AN able.
// - Expansion bit 2 reads zero: no local next page support.
// - Expansion bits 15:5 and advertisement bit 14 read zero.
// - Indices eight to fifteen have no function and read zero.
// - Unit bit 13 writable, resets zero, enables carrier disconnect.
// - Unit bit 12 writable, resets zero, one enables transmit flow control.
// - Unit bit 11 reports 100 Mb/s deserializer in sync.
// - Unit bits 10 and 9 show power-down, read one after reset.
// - Unit bit 8 reads one on reversed 10 Mb/s polarity.
// - Unit bits 1 and 0 report resolved speed and duplex.
// - Unit bits 15:14 writable, reset zero, read back as written; bits 7:2 read zero.
// - Basic control bit 9 restarts negotiation and clears itself.
// - With basic control bit 12 set, manual speed and duplex ignored.
`timescale 1ns/1ns
module pas_regs (
    // Clock and reset
    input wire logic clk_in,
    input wire logic arst_n_in,
    // Management register access
    input wire logic [4:0] reg_addr_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    input wire logic [15:0] reg_wdata_in,
    output logic [15:0] reg_rdata_out,
    // Negotiation engine
    input wire logic partner_page_valid_in,
    input wire logic [15:0] partner_page_in,
    input wire logic partner_an_able_in,
    input wire logic pd_fault_in,
    input wire logic an_complete_in,
    output logic [15:0] adv_page_out,
    output logic an_restart_out,
    output logic an_enable_out,
    // Analog status pins
    input wire logic rx_in_sync_in,
    input wire logic pd_100_in,
    input wire logic pd_10_in,
    input wire logic rx_pol_reversed_in,
    // Control and result
    output logic carrier_disc_en_out,
    output logic tx_flow_ctrl_en_out,
    output logic speed_100_out,
    output logic full_duplex_out
);
    logic rst_meta_q;
    logic rst_n_q;
    logic [3:0] stat_sync;
    logic bc_speed_q;
    logic bc_an_en_q;
    logic bc_duplex_q;
    logic restart_q;
    logic adv_rfault_q;
    logic [7:0] adv_tech_q;
    logic [15:0] partner_q;
    logic partner_ack_q;
    logic pd_fault_q;
    logic page_rx_q;
    logic lp_an_able_q;
    logic [1:0] us_rsvd_q;
    logic disc_en_q;
    logic txfc_en_q;
    logic res_speed;
    logic res_duplex;
    logic [15:0] adv_word;
    logic [15:0] bc_word;
    logic [15:0] partner_word;
    logic [15:0] exp_word;
    logic [15:0] us_word;
    logic [15:0] rd_word;
    logic wr_bc;
    logic wr_adv;
    logic wr_us;
    logic rd_exp;

    // Reset release through two flops
    always_ff @(posedge clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            rst_meta_q <= 1'b0;
            rst_n_q <= 1'b0;
        end
        else
        begin
            rst_meta_q <= 1'b1;
            rst_n_q <= rst_meta_q;
        end
    end

    // Analog status arrives asynchronously
    pas_sync #(
        .WIDTH(4),
        .RST_VAL(pas_pkg::PAS_STAT_RST)
    ) u_stat_sync (
        .clk_in(clk_in),
        .rst_n_in(rst_n_q),
        .d_in({rx_in_sync_in, pd_100_in, pd_10_in, rx_pol_reversed_in}),
        .q_out(stat_sync)
    );

    pas_resolve u_resolve (
        .local_tech_in(adv_tech_q),
        .partner_tech_in(partner_q[pas_pkg::PAS_ADV_TECH_HI:
                                   pas_pkg::PAS_ADV_TECH_LO]),
        .speed_100_out(res_speed),
        .full_duplex_out(res_duplex)
    );

    assign wr_bc = reg_wr_in && (reg_addr_in == pas_pkg::PAS_OFS_BASIC_CTRL);
    assign wr_adv = reg_wr_in && (reg_addr_in == pas_pkg::PAS_OFS_ADVERTISE);
    assign wr_us = reg_wr_in && (reg_addr_in == pas_pkg::PAS_OFS_UNIT_STATUS);
    // Only the expansion register has read side effects
    assign rd_exp = reg_rd_in && (reg_addr_in == pas_pkg::PAS_OFS_EXPANSION);

    // Basic control subset: speed, enable, duplex; restart is handled below
    always_ff @(posedge clk_in or negedge rst_n_q)
    begin
        if (!rst_n_q)
        begin
            bc_speed_q <= pas_pkg::PAS_BC_SPEED_RST;
            bc_an_en_q <= pas_pkg::PAS_BC_AN_EN_RST;
            bc_duplex_q <= pas_pkg::PAS_BC_DUPLEX_RST;
        end
        else if (wr_bc)
        begin
            bc_speed_q <= reg_wdata_in[pas_pkg::PAS_BC_SPEED_BIT];
            bc_an_en_q <= reg_wdata_in[pas_pkg::PAS_BC_AN_EN_BIT];
            bc_duplex_q <= reg_wdata_in[pas_pkg::PAS_BC_DUPLEX_BIT];
        end
    end

    // Restart is one cycle wide, then reads back as zero
    always_ff @(posedge clk_in or negedge rst_n_q)
    begin
        if (!rst_n_q)
        begin
            restart_q <= 1'b0;
        end
        else
        begin
            restart_q <= wr_bc
                         && reg_wdata_in[pas_pkg::PAS_BC_RESTART_BIT];
        end
    end

    // Advertisement writable fields
    always_ff @(posedge clk_in or negedge rst_n_q)
    begin
        if (!rst_n_q)
        begin
            adv_rfault_q <= pas_pkg::PAS_ADV_RFAULT_RST;
            adv_tech_q <= pas_pkg::PAS_ADV_TECH_RST;
        end
        else if (wr_adv)
        begin
            adv_rfault_q <=
                reg_wdata_in[pas_pkg::PAS_ADV_RFAULT_BIT];
            adv_tech_q <= reg_wdata_in[pas_pkg::PAS_ADV_TECH_HI:
                                       pas_pkg::PAS_ADV_TECH_LO];
        end
    end

    // Partner page capture; a restart forgets the old partner
    always_ff @(posedge clk_in or negedge rst_n_q)
    begin
        if (!rst_n_q)
        begin
            partner_q <= 16'h0000;
            partner_ack_q <= 1'b0;
        end
        else if (partner_page_valid_in)
        begin
            partner_q <= partner_page_in;
            partner_ack_q <= 1'b1;
        end
        else if (restart_q)
        begin
            partner_q <= 16'h0000;
            partner_ack_q <= 1'b0;
        end
    end

    // Latched events: a set in the read cycle survives the clear
    always_ff @(posedge clk_in or negedge rst_n_q)
    begin
        if (!rst_n_q)
        begin
            pd_fault_q <= 1'b0;
            page_rx_q <= 1'b0;
        end
        else
        begin
            pd_fault_q <= pd_fault_in || (pd_fault_q && !rd_exp);
            page_rx_q <= partner_page_valid_in
                         || (page_rx_q && !rd_exp);
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_q)
    begin
        if (!rst_n_q)
        begin
            lp_an_able_q <= 1'b0;
        end
        else
        begin
            lp_an_able_q <= partner_an_able_in;
        end
    end

    // Unit status and control writable bits
    always_ff @(posedge clk_in or negedge rst_n_q)
    begin
        if (!rst_n_q)
        begin
            us_rsvd_q <= pas_pkg::PAS_US_RSVD_RST;
            disc_en_q <= pas_pkg::PAS_US_DISC_RST;
            txfc_en_q <= pas_pkg::PAS_US_TXFC_RST;
        end
        else if (wr_us)
        begin
            us_rsvd_q <= reg_wdata_in[pas_pkg::PAS_US_RSVD_HI:
                                      pas_pkg::PAS_US_RSVD_LO];
            disc_en_q <= reg_wdata_in[pas_pkg::PAS_US_DISC_BIT];
            txfc_en_q <= reg_wdata_in[pas_pkg::PAS_US_TXFC_BIT];
        end
    end

    // Read words; read-only fields are built, never stored from writes
    always_comb
    begin
        bc_word = 16'h0000;
        bc_word[pas_pkg::PAS_BC_SPEED_BIT] = bc_speed_q;
        bc_word[pas_pkg::PAS_BC_AN_EN_BIT] = bc_an_en_q;
        bc_word[pas_pkg::PAS_BC_DUPLEX_BIT] = bc_duplex_q;
        adv_word = 16'h0000;
        adv_word[pas_pkg::PAS_ADV_RFAULT_BIT] = adv_rfault_q;
        adv_word[pas_pkg::PAS_ADV_TECH_HI:pas_pkg::PAS_ADV_TECH_LO] =
            adv_tech_q;
        adv_word[4:0] = pas_pkg::PAS_ADV_SELECTOR;
        partner_word = partner_q;
        partner_word[pas_pkg::PAS_ADV_ACK_BIT] = partner_ack_q;
        exp_word = 16'h0000;
        exp_word[pas_pkg::PAS_EXP_PD_FAULT_BIT] = pd_fault_q;
        exp_word[pas_pkg::PAS_EXP_LP_NP_BIT] =
            partner_q[pas_pkg::PAS_ADV_NEXT_PAGE_BIT];
        exp_word[pas_pkg::PAS_EXP_NP_ABLE_BIT] =
            pas_pkg::PAS_EXP_NP_ABLE;
        exp_word[pas_pkg::PAS_EXP_PAGE_RX_BIT] = page_rx_q;
        exp_word[pas_pkg::PAS_EXP_LP_AN_BIT] = lp_an_able_q;
        us_word = 16'h0000;
        us_word[pas_pkg::PAS_US_RSVD_HI:pas_pkg::PAS_US_RSVD_LO] = us_rsvd_q;
        us_word[pas_pkg::PAS_US_DISC_BIT] = disc_en_q;
        us_word[pas_pkg::PAS_US_TXFC_BIT] = txfc_en_q;
        us_word[pas_pkg::PAS_US_SYNC_BIT] = stat_sync[3];
        us_word[pas_pkg::PAS_US_PD100_BIT] = stat_sync[2];
        us_word[pas_pkg::PAS_US_PD10_BIT] = stat_sync[1];
        us_word[pas_pkg::PAS_US_POL_BIT] = stat_sync[0];
        us_word[pas_pkg::PAS_US_SPEED_BIT] = speed_100_out;
        us_word[pas_pkg::PAS_US_DUPLEX_BIT] = full_duplex_out;
        if (reg_addr_in == pas_pkg::PAS_OFS_BASIC_CTRL)
        begin
            rd_word = bc_word;
        end
        else if (reg_addr_in == pas_pkg::PAS_OFS_ADVERTISE)
        begin
            rd_word = adv_word;
        end
        else if (reg_addr_in == pas_pkg::PAS_OFS_PARTNER)
        begin
            rd_word = partner_word;
        end
        else if (reg_addr_in == pas_pkg::PAS_OFS_EXPANSION)
        begin
            rd_word = exp_word;
        end
        else if (reg_addr_in == pas_pkg::PAS_OFS_UNIT_STATUS)
        begin
            rd_word = us_word;
        end
        else
        begin
            // Eight to fifteen and unmapped indices read zero
            rd_word = 16'h0000;
        end
    end

    // Read data held until the next read
    always_ff @(posedge clk_in or negedge rst_n_q)
    begin
        if (!rst_n_q)
        begin
            reg_rdata_out <= 16'h0000;
        end
        else if (reg_rd_in)
        begin
            reg_rdata_out <= rd_word;
        end
    end

    // Result: negotiated when enabled, otherwise manual selection
    always_ff @(posedge clk_in or negedge rst_n_q)
    begin
        if (!rst_n_q)
        begin
            speed_100_out <= 1'b0;
            full_duplex_out <= 1'b0;
        end
        else if (!bc_an_en_q)
        begin
            speed_100_out <= bc_speed_q;
            full_duplex_out <= bc_duplex_q;
        end
        else if (an_complete_in && partner_ack_q)
        begin
            speed_100_out <= res_speed;
            full_duplex_out <= res_duplex;
        end
    end

    // Registered control outputs
    always_ff @(posedge clk_in or negedge rst_n_q)
    begin
        if (!rst_n_q)
        begin
            adv_page_out <= 16'h0000;
            an_restart_out <= 1'b0;
            an_enable_out <= 1'b0;
            carrier_disc_en_out <= 1'b0;
            tx_flow_ctrl_en_out <= 1'b0;
        end
        else
        begin
            adv_page_out <= adv_word;
            an_restart_out <= restart_q;
            an_enable_out <= bc_an_en_q;
            carrier_disc_en_out <= disc_en_q;
            tx_flow_ctrl_en_out <= txfc_en_q;
        end
    end
endmodule : pas_regs

//--- pas_partner.sv
// Link partner model: sends one base page per request, then completes
`timescale 1ns/1ns
module pas_partner (
    // Clock
    input wire logic clk_in,
    // Bench requests
    input wire logic send_in,
    input wire logic fault_in,
    input wire logic restart_in,
    input wire logic [15:0] page_in,
    // Negotiation side
    output logic page_valid_out = 1'b0,
    output logic [15:0] page_out = 16'h0000,
    output logic an_able_out = 1'b0,
    output logic pd_fault_out = 1'b0,
    output logic complete_out = 1'b0
);
    logic [2:0] step_q = 3'h0;
    logic [15:0] held_q = 16'h0000;
    always @(posedge clk_in)
    begin
        page_valid_out <= 1'b0;
        pd_fault_out <= fault_in;
        // Page lines are not held once the strobe has gone
        page_out <= ~held_q;
        if (send_in)
        begin
            step_q <= 3'h1;
            held_q <= page_in;
            complete_out <= 1'b0;
        end
        else if (step_q != 3'h0)
            step_q <= step_q + 3'h1;
        if (step_q == 3'h2)
        begin
            page_valid_out <= 1'b1;
            page_out <= held_q;
            an_able_out <= 1'b1;
        end
        if (step_q == 3'h4)
        begin
            complete_out <= 1'b1;
            step_q <= 3'h0;
        end
        // A restart throws away the finished negotiation
        if (restart_in)
            complete_out <= 1'b0;
    end
endmodule : pas_partner

//--- pas_regs_sva.sv
// Port-level assertions for the register bank
`timescale 1ns/1ns
module pas_regs_sva (
    // Clock and reset
    input wire logic clk_in,
    input wire logic arst_n_in,
    // Register access
    input wire logic [4:0] reg_addr_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    input wire logic [15:0] reg_wdata_in,
    input wire logic [15:0] reg_rdata_out,
    // Negotiation and control
    input wire logic partner_page_valid_in,
    input wire logic pd_fault_in,
    input wire logic [15:0] adv_page_out,
    input wire logic an_restart_out,
    input wire logic carrier_disc_en_out,
    input wire logic tx_flow_ctrl_en_out
);
    logic [2:0] up_q;
    logic seen_q;
    logic ack_q;
    // Internal reset lags the pin by two edges, registered outputs by three
    always_ff @(posedge clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
            up_q <= 3'h0;
        else if (up_q != 3'h4)
            up_q <= up_q + 3'h1;
    end
    always_ff @(posedge clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
            seen_q <= 1'b0;
        else if (partner_page_valid_in)
            seen_q <= 1'b1;
        else if (reg_rd_in && reg_addr_in == 5'h06)
            seen_q <= 1'b0;
    end
    always_ff @(posedge clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
            ack_q <= 1'b0;
        else if (partner_page_valid_in)
            ack_q <= 1'b1;
        else if (reg_wr_in && reg_addr_in == 5'h00 && reg_wdata_in[9])
            ack_q <= 1'b0;
    end
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (up_q != 3'h4);
    sequence rd6_quiet;
        reg_rd_in && reg_addr_in == 5'h06 && !partner_page_valid_in
            && !pd_fault_in;
    endsequence
    sequence restart_req;
        reg_wr_in && reg_addr_in == 5'h00 && reg_wdata_in[9];
    endsequence
    adv_fixed_a: assert property (
        adv_page_out[15:14] == 2'h0 && adv_page_out[4:0] == 5'h01)
        else $error("advertised page fixed bits wrong");
    adv_write_a: assert property (
        reg_wr_in && reg_addr_in == 5'h04 |-> ##2
        adv_page_out[13:5] == $past(reg_wdata_in[13:5], 2))
        else $error("advertised page does not follow write");
    exp_rsvd_a: assert property (
        reg_rd_in && reg_addr_in == 5'h06 |=>
        reg_rdata_out[15:5] == 11'h000 && !reg_rdata_out[2])
        else $error("expansion reserved bits not zero");
    unmapped_zero_a: assert property (
        reg_rd_in && reg_addr_in[4:3] == 2'h1 |=> reg_rdata_out == 16'h0000)
        else $error("reserved index read not zero");
    restart_pulse_a: assert property (
        restart_req |-> ##2 an_restart_out ##1 !an_restart_out)
        else $error("restart pulse missing or too long");
    unit_ctrl_a: assert property (
        reg_wr_in && reg_addr_in == 5'h10 |-> ##2
        carrier_disc_en_out == $past(reg_wdata_in[13], 2)
        && tx_flow_ctrl_en_out == $past(reg_wdata_in[12], 2))
        else $error("unit control outputs do not follow write");
    page_flag_a: assert property (
        reg_rd_in && reg_addr_in == 5'h06 && seen_q |=> reg_rdata_out[1])
        else $error("page received flag not shown");
    partner_ack_a: assert property (
        reg_rd_in && reg_addr_in == 5'h05 && ack_q |=> reg_rdata_out[14])
        else $error("partner acknowledge not shown");
    clear_read_a: assert property (
        rd6_quiet ##1 (!partner_page_valid_in && !pd_fault_in) ##1 rd6_quiet
        |=> !reg_rdata_out[4] && !reg_rdata_out[1])
        else $error("latched expansion bits not cleared by read");
    rdata_hold_a: assert property (
        !reg_rd_in |=> $stable(reg_rdata_out))
        else $error("read data changed without a read");
endmodule : pas_regs_sva
bind pas_regs pas_regs_sva u_sva (
    .clk_in(clk_in),
    .arst_n_in(arst_n_in),
    .reg_addr_in(reg_addr_in),
    .reg_wr_in(reg_wr_in),
    .reg_rd_in(reg_rd_in),
    .reg_wdata_in(reg_wdata_in),
    .reg_rdata_out(reg_rdata_out),
    .partner_page_valid_in(partner_page_valid_in),
    .pd_fault_in(pd_fault_in),
    .adv_page_out(adv_page_out),
    .an_restart_out(an_restart_out),
    .carrier_disc_en_out(carrier_disc_en_out),
    .tx_flow_ctrl_en_out(tx_flow_ctrl_en_out)
);

//--- pas_regs_tb.sv
// Self-checking bench for the register bank with a link partner model
`timescale 1ns/1ns
module pas_regs_tb;
    logic clk_in = 1'b0;
    logic arst_n_in = 1'b0;
    logic [4:0] reg_addr_in = 5'h00;
    logic reg_wr_in = 1'b0;
    logic reg_rd_in = 1'b0;
    logic [15:0] reg_wdata_in = 16'h0000;
    logic [15:0] reg_rdata_out;
    logic page_v;
    logic an_able;
    logic pd_fault;
    logic an_done;
    logic [15:0] page;
    logic send = 1'b0;
    logic fault_req = 1'b0;
    logic [15:0] send_page = 16'h0000;
    logic [3:0] pins = 4'h6;
    logic [15:0] adv_page_out;
    logic an_restart_out;
    logic an_enable_out;
    logic carrier_disc_en_out;
    logic tx_flow_ctrl_en_out;
    logic speed_100_out;
    logic full_duplex_out;
    logic rd_prev = 1'b0;
    logic [15:0] exp_q[$];
    logic [31:0] seed = 32'h73E5B20A;
    int fails = 0;
    int samples_checked = 0;
    always #5 clk_in = ~clk_in;
    pas_regs dut (
        .clk_in(clk_in), .arst_n_in(arst_n_in), .reg_addr_in(reg_addr_in),
        .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
        .reg_wdata_in(reg_wdata_in), .reg_rdata_out(reg_rdata_out),
        .partner_page_valid_in(page_v), .partner_page_in(page),
        .partner_an_able_in(an_able), .pd_fault_in(pd_fault),
        .an_complete_in(an_done), .adv_page_out(adv_page_out),
        .an_restart_out(an_restart_out), .an_enable_out(an_enable_out),
        .rx_in_sync_in(pins[3]), .pd_100_in(pins[2]), .pd_10_in(pins[1]),
        .rx_pol_reversed_in(pins[0]),
        .carrier_disc_en_out(carrier_disc_en_out),
        .tx_flow_ctrl_en_out(tx_flow_ctrl_en_out),
        .speed_100_out(speed_100_out), .full_duplex_out(full_duplex_out));
    pas_partner u_lp (
        .clk_in(clk_in), .send_in(send), .fault_in(fault_req),
        .restart_in(an_restart_out), .page_in(send_page),
        .page_valid_out(page_v), .page_out(page), .an_able_out(an_able),
        .pd_fault_out(pd_fault), .complete_out(an_done));
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction : xs
    // Highest common ability: {speed, duplex}
    function automatic logic [1:0] best(input logic [7:0] c);
        if (c[3]) return 2'h3;
        if (c[2] || c[4]) return 2'h2;
        if (c[1]) return 2'h1;
        return 2'h0;
    endfunction : best
    task automatic check(input string name, input logic [15:0] seen,
        input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            fails++;
            $display("unexpected %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : end_of_test
    task automatic idle(input int n);
        repeat (n) @(posedge clk_in);
    endtask : idle
    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        @(posedge clk_in);
        reg_addr_in <= a;
        reg_wdata_in <= d;
        reg_wr_in <= 1'b1;
        @(posedge clk_in);
        reg_wr_in <= 1'b0;
    endtask : wr
    task automatic rd(input logic [4:0] a, input logic [15:0] e);
        @(posedge clk_in);
        reg_addr_in <= a;
        reg_rd_in <= 1'b1;
        exp_q.push_back(e);
        @(posedge clk_in);
        reg_rd_in <= 1'b0;
    endtask : rd
    // Read data lands one edge after the read is taken
    always @(posedge clk_in)
        rd_prev <= reg_rd_in;
    always @(negedge clk_in)
        if (rd_prev)
            check("reg_rdata_out", reg_rdata_out, exp_q.pop_front());
    initial
    begin
        idle(5000);
        fails++;
        end_of_test;
    end
    initial
    begin
        logic [15:0] p;
        logic [7:0] t;
        logic [1:0] sd;
        idle(10);
        arst_n_in <= 1'b1;
        idle(4);
        rd(5'h00, 16'h3000);
        rd(5'h04, 16'h05E1);
        rd(5'h05, 16'h0000);
        rd(5'h06, 16'h0000);
        rd(5'h10, 16'h0600);
        wr(5'h04, 16'hFFFF);
        rd(5'h04, 16'h3FE1);
        for (int a = 5; a < 16; a++)
        begin
            wr(a[4:0], 16'hFFFF);
            rd(a[4:0], 16'h0000);
        end
        repeat (4)
        begin
            seed = xs(seed);
            pins <= seed[3:0];
            wr(5'h10, {2'h0, seed[5:4], 12'hFFF});
            idle(6);
            check("ctrl", {14'h0, carrier_disc_en_out, tx_flow_ctrl_en_out},
                {14'h0, seed[5:4]});
            rd(5'h10, {2'h0, seed[5:4], seed[3:0], 8'h00});
        end
        wr(5'h10, 16'h0000);
        repeat (3)
        begin
            seed = xs(seed);
            t = seed[7:0];
            p = seed[31:16];
            wr(5'h04, {2'h0, seed[8], t, 5'h00});
            // Stored on the write edge, copied out one edge later
            idle(2);
            check("adv_page_out", adv_page_out,
                {2'h0, seed[8], t, 5'h01});
            send_page <= p;
            send <= 1'b1;
            idle(1);
            send <= 1'b0;
            idle(8);
            rd(5'h05, {p[15], 1'b1, p[13:0]});
            rd(5'h06, {12'h000, p[15], 3'h3});
            rd(5'h06, {12'h000, p[15], 3'h1});
            sd = best(t & p[12:5]);
            check("speed_duplex", {14'h0, speed_100_out, full_duplex_out},
                {14'h0, sd});
            rd(5'h10, {4'h0, pins, 6'h00, sd});
        end
        fault_req <= 1'b1;
        idle(1);
        fault_req <= 1'b0;
        idle(4);
        rd(5'h06, {11'h000, 1'b1, p[15], 3'h1});
        rd(5'h06, {11'h000, 1'b0, p[15], 3'h1});
        wr(5'h00, 16'h1200);
        idle(4);
        rd(5'h05, 16'h0000);
        rd(5'h00, 16'h1000);
        wr(5'h00, 16'h2100);
        idle(2);
        check("manual", {13'h0, an_enable_out, speed_100_out,
            full_duplex_out}, 16'h0003);
        wr(5'h00, 16'h0000);
        idle(2);
        check("manual", {13'h0, an_enable_out, speed_100_out,
            full_duplex_out}, 16'h0000);
        end_of_test;
    end
endmodule : pas_regs_tb
